/* core/urx_defs.svh */
// constants of the serial receiver: register offsets, fields, resets
// assumes inclusion by urx_pkg and the design modules only
`ifndef URX_DEFS_SVH
`define URX_DEFS_SVH

// register byte offsets
`define URX_OFF_CTRL 12'h000
`define URX_OFF_STATUS 12'h004
`define URX_OFF_DATA 12'h008

// ctrl_status_a control fields
`define URX_CTRL_FILTER 0
`define URX_CTRL_DOUBLE 1
`define URX_CTRL_SIZE_LO 2
`define URX_CTRL_SIZE_HI 4
`define URX_CTRL_TWO_STOP 5
`define URX_CTRL_RX_EN 6
`define URX_CTRL_PAR_EN 7
`define URX_CTRL_PAR_ODD 8
`define URX_CTRL_WIDTH 9
`define URX_CTRL_RESET 9'h00C

// status fields
`define URX_ST_COMPLETE 0
`define URX_ST_FRAME_ERR 1
`define URX_ST_NINTH 2
`define URX_ST_OVERRUN 3
`define URX_ST_PAR_ERR 4

// sample states per bit and first voting sample
`define URX_SAMPLES_NORMAL 5'h10
`define URX_SAMPLES_DOUBLE 5'h08
`define URX_FIRST_NORMAL 5'h08
`define URX_FIRST_DOUBLE 5'h04

// character size code of nine data bits
`define URX_SIZE_NINE 3'h7
`define URX_FRAME_MAX 10

`endif

/* core/urx_pkg.sv */
// types of the serial receiver: states and register state records
// assumes urx_defs.svh on the include path
package urx_pkg;
`include "urx_defs.svh"

	typedef enum logic [1:0] {
		URX_IDLE = 2'b00,
		URX_START = 2'b01,
		URX_DATA = 2'b10,
		URX_STOP = 2'b11
	} urx_state_t;

	typedef struct packed {
		urx_state_t state;
		logic [4:0] cnt;
		logic [3:0] bit_idx;
		logic [1:0] votes;
		logic [`URX_FRAME_MAX-1:0] bits;
		logic stop_bit;
		logic done;
	} urx_rec_t;

	typedef struct packed {
		logic [8:0] data;
		logic frame_err;
		logic par_err;
	} urx_entry_t;

	typedef struct packed {
		logic [`URX_CTRL_WIDTH-1:0] ctrl;
		urx_entry_t [1:0] fifo;
		logic rd_ptr;
		logic wr_ptr;
		logic [1:0] count;
		logic overrun;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} urx_top_t;
endpackage

/* core/urx_rec_if.sv */
// link between the register top and the bit recovery engine
// assumes one clock shared by both ends
`timescale 1ns/1ns
interface urx_rec_if;
	logic enable;
	logic dbl;
	logic [3:0] nbits;
	logic frame_valid;
	logic [9:0] frame_bits;
	logic frame_stop;

	modport ctrl (output enable, output dbl, output nbits,
		input frame_valid, input frame_bits, input frame_stop);
	modport rec (input enable, input dbl, input nbits,
		output frame_valid, output frame_bits, output frame_stop);
endinterface

/* core/urx_bit_recovery.sv */
// oversampling bit recovery with three-sample majority vote
// assumes sample_tick pulses at 16x (or 8x in double speed) the bit rate
`timescale 1ns/1ns
`include "urx_defs.svh"
module urx_bit_recovery
	import urx_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// line side
	input wire logic sample_tick,
	input wire logic rx_serial_pin,
	// engine link
	urx_rec_if.rec rif
);

	urx_rec_t r_reg;
	urx_rec_t r_next;

	always_comb
	begin
		logic [4:0] spb;
		logic [4:0] first;
		logic [4:0] c;
		logic v;
		spb = rif.dbl ? `URX_SAMPLES_DOUBLE : `URX_SAMPLES_NORMAL;
		first = rif.dbl ? `URX_FIRST_DOUBLE : `URX_FIRST_NORMAL;
		c = r_reg.cnt + 5'h01;
		v = 1'b0;
		r_next = r_reg;
		r_next.done = 1'b0;
		if (!rif.enable)
		begin
			r_next.state = URX_IDLE;
			r_next.cnt = 5'h00;
		end
		else if (sample_tick)
		begin
			case (r_reg.state)
				URX_IDLE:
				begin
					if (!rx_serial_pin)
					begin
						r_next.state = URX_START;
						r_next.cnt = 5'h01;
						r_next.bits = '0;
					end
				end
				URX_START, URX_DATA, URX_STOP:
				begin
					r_next.cnt = (c == spb) ? 5'h00 : c;
					// samples first and first+1 kept, first+2 closes vote
					if (c == first)
						r_next.votes[0] = rx_serial_pin;
					if (c == first + 5'h01)
						r_next.votes[1] = rx_serial_pin;
					v = (r_reg.votes[0] & r_reg.votes[1]) |
						(r_reg.votes[0] & rx_serial_pin) |
						(r_reg.votes[1] & rx_serial_pin);
					if (c == first + 5'h02)
					begin
						if (r_reg.state == URX_START && v)
						begin
							r_next.state = URX_IDLE;
							r_next.cnt = 5'h00;
						end
						else if (r_reg.state == URX_DATA)
							r_next.bits[r_reg.bit_idx] = v;
						else if (r_reg.state == URX_STOP)
						begin
							r_next.stop_bit = v;
							r_next.done = 1'b1;
							if (!rif.dbl)
							begin
								r_next.state = URX_IDLE;
								r_next.cnt = 5'h00;
							end
						end
					end
					else if (c == spb)
					begin
						if (r_reg.state == URX_START)
						begin
							r_next.state = URX_DATA;
							r_next.bit_idx = 4'h0;
						end
						else if (r_reg.state == URX_DATA)
						begin
							r_next.bit_idx = r_reg.bit_idx + 4'h1;
							if (r_reg.bit_idx + 4'h1 == rif.nbits)
								r_next.state = URX_STOP;
						end
						else
							r_next.state = URX_IDLE;
					end
				end
				default:
				begin
					r_next.state = URX_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	assign rif.frame_valid = r_reg.done;
	assign rif.frame_bits = r_reg.bits;
	assign rif.frame_stop = r_reg.stop_bit;

endmodule // urx_bit_recovery

/* core/urx_top.sv */
// serial receiver top: APB registers, frame filter, two-entry buffer
// assumes an external baud generator giving sample_tick on pclk
`timescale 1ns/1ns
`include "urx_defs.svh"
// Summary of operation
// - each bit except a normal-speed stop bit is walked through 16 sample states, 8 in double speed
// - bit level comes from a vote of three centre samples
// - two or three high samples give 1, otherwise 0
// - first voting sample is 8, or 4 in double speed
// - middle voting sample is 9, or 5 in double speed
// - recovery runs through the first stop bit; later stops are ignored
// - a stop bit voting 0 sets the stored frame error flag
// - normal speed looks for a new start right after stop voting
// - data plus parity bits may total five to ten
// - with filtering on, data frames are dropped before the buffer
// - filter setting never touches the transmitter
// - frame type is first stop bit, or ninth bit for 9-bit frames
// - frame type one means address, zero means data
// - address frames under filtering are stored and flagged as usual
// - one character size setting serves receiver and transmitter
// - start is rejected when two of three centre samples are high
// - double speed cuts the sample divider from 16 to 8
module urx_top
	import urx_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial line and sample tick
	input wire logic sample_tick,
	input wire logic rx_serial_pin,
	// settings shared with transmitter and baud generator
	output logic [2:0] char_size_sel,
	output logic two_stop_sel,
	output logic double_speed_sel
);

	urx_rec_if rif ();

	urx_top_t s_reg;
	urx_top_t s_next;

	logic [3:0] data_bits;
	logic [8:0] bit_mask;
	logic [8:0] data_masked;
	logic [8:0] par_terms;
	logic par_bit;
	logic frame_type;
	logic ninth;
	urx_entry_t head;

	// character size decode, shared with the transmitter
	always_comb
	begin
		case (s_reg.ctrl[`URX_CTRL_SIZE_HI:`URX_CTRL_SIZE_LO])
			3'h0: data_bits = 4'h5;
			3'h1: data_bits = 4'h6;
			3'h2: data_bits = 4'h7;
			3'h3: data_bits = 4'h8;
			`URX_SIZE_NINE: data_bits = 4'h9;
			default: data_bits = 4'h8;
		endcase
	end

	assign rif.enable = s_reg.ctrl[`URX_CTRL_RX_EN];
	assign rif.dbl = s_reg.ctrl[`URX_CTRL_DOUBLE];
	assign rif.nbits = data_bits +
		{3'h0, s_reg.ctrl[`URX_CTRL_PAR_EN]};

	// per-bit data mask and parity terms
	genvar gi;
	generate
		for (gi = 0; gi < 9; gi = gi + 1)
		begin : g_bit
			assign bit_mask[gi] = (4'(gi) < data_bits);
			assign data_masked[gi] = rif.frame_bits[gi] & bit_mask[gi];
			assign par_terms[gi] = data_masked[gi];
		end
	endgenerate

	assign par_bit = rif.frame_bits[data_bits];
	assign ninth = (data_bits == 4'h9) ? rif.frame_bits[8] : 1'b0;
	// frame type bit selection
	assign frame_type = (data_bits == 4'h9) ? rif.frame_bits[8] :
		rif.frame_stop;
	assign head = s_reg.fifo[s_reg.rd_ptr];

	urx_bit_recovery u_rec (
		.pclk(pclk),
		.presetn(presetn),
		.sample_tick(sample_tick),
		.rx_serial_pin(rx_serial_pin),
		.rif(rif)
	);

	always_comb
	begin
		logic setup;
		logic access;
		logic pop;
		logic push;
		logic mapped;
		logic [31:0] rd;
		urx_entry_t e;
		setup = psel && !penable;
		access = psel && penable && s_reg.pready;
		mapped = (paddr == `URX_OFF_CTRL) || (paddr == `URX_OFF_STATUS) ||
			(paddr == `URX_OFF_DATA);
		pop = access && !pwrite && (paddr == `URX_OFF_DATA) &&
			(s_reg.count != 2'h0);
		push = 1'b0;
		rd = 32'h0000_0000;
		e = '0;
		s_next = s_reg;

		// apb answer: registered in setup, shown in the first access cycle
		s_next.pready = setup;
		s_next.pslverr = setup && !mapped;
		if (setup && !pwrite)
		begin
			case (paddr)
				`URX_OFF_CTRL:
					rd[`URX_CTRL_WIDTH-1:0] = s_reg.ctrl;
				`URX_OFF_STATUS:
				begin
					rd[`URX_ST_COMPLETE] = (s_reg.count != 2'h0);
					rd[`URX_ST_FRAME_ERR] = (s_reg.count != 2'h0) &&
						head.frame_err;
					rd[`URX_ST_NINTH] = (s_reg.count != 2'h0) && head.data[8];
					rd[`URX_ST_OVERRUN] = s_reg.overrun;
					rd[`URX_ST_PAR_ERR] = (s_reg.count != 2'h0) &&
						head.par_err;
				end
				`URX_OFF_DATA:
					rd[7:0] = (s_reg.count != 2'h0) ? head.data[7:0] : 8'h00;
				default:
					rd = 32'h0000_0000;
			endcase
			s_next.prdata = rd;
		end
		else if (setup)
			s_next.prdata = 32'h0000_0000;

		// control write; filter bit only gates reception
		if (access && pwrite && (paddr == `URX_OFF_CTRL))
			s_next.ctrl = pwdata[`URX_CTRL_WIDTH-1:0];

		// frame arrival: classify, filter, store
		if (rif.frame_valid)
		begin
			e.data = {ninth, data_masked[7:0]};
			e.frame_err = !rif.frame_stop;
			e.par_err = s_reg.ctrl[`URX_CTRL_PAR_EN] &&
				((^par_terms) ^ par_bit ^ s_reg.ctrl[`URX_CTRL_PAR_ODD]);
			// address frames (type one) pass; data frames drop if filtering
			push = !(s_reg.ctrl[`URX_CTRL_FILTER] && !frame_type);
		end

		if (push && (s_reg.count == 2'h2) && !pop)
		begin
			s_next.overrun = 1'b1;
			push = 1'b0;
		end
		else if (push)
			s_next.overrun = 1'b0;

		if (push)
		begin
			s_next.fifo[s_reg.wr_ptr] = e;
			s_next.wr_ptr = !s_reg.wr_ptr;
		end
		if (pop)
			s_next.rd_ptr = !s_reg.rd_ptr;
		case ({push, pop})
			2'b10: s_next.count = s_reg.count + 2'h1;
			2'b01: s_next.count = s_reg.count - 2'h1;
			default: s_next.count = s_reg.count;
		endcase

		// receiver disabled: buffer flushed
		if (!s_reg.ctrl[`URX_CTRL_RX_EN])
		begin
			s_next.count = 2'h0;
			s_next.rd_ptr = 1'b0;
			s_next.wr_ptr = 1'b0;
			s_next.overrun = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_reg <= '0;
			s_reg.ctrl <= `URX_CTRL_RESET;
		end
		else
			s_reg <= s_next;
	end

	assign prdata = s_reg.prdata;
	assign pready = s_reg.pready;
	assign pslverr = s_reg.pslverr;
	assign char_size_sel = s_reg.ctrl[`URX_CTRL_SIZE_HI:`URX_CTRL_SIZE_LO];
	assign two_stop_sel = s_reg.ctrl[`URX_CTRL_TWO_STOP];
	assign double_speed_sel = s_reg.ctrl[`URX_CTRL_DOUBLE];

endmodule // urx_top

/* verif/urx_tx_model.sv */
// far-side serial transmitter and sample tick source
// assumes the bench pclk; the line idles high
`timescale 1ns/1ns
module urx_tx_model (
	// clock and speed
	input wire logic pclk,
	input wire logic dbl,
	// line side
	output logic tick,
	output logic line
);
	logic ph;
	initial
	begin
		ph = 1'h0;
		tick = 1'h0;
		line = 1'h1;
	end
	// one sample every second pclk, exact rate
	always @(posedge pclk)
	begin
		ph <= ~ph;
		tick <= ph;
	end
	task automatic tk();
		do @(posedge pclk); while (tick !== 1'h1);
	endtask
	// hold a level for n samples; spk flips the middle vote sample
	task automatic bitout(input logic v, input int n, input logic spk);
		line <= v;
		for (int i = 1; i <= n; i++)
		begin
			tk();
			if (i < n)
				line <= (spk && i == (dbl ? 4 : 8)) ? ~v : v;
		end
	endtask
	// one frame, lsb first, ends on the stop level fs, or high after a second stop when two is set
	task automatic send(input logic [9:0] d, input int nb, input logic fs,
		input logic two, input int st, input logic spk);
		bitout(1'h0, dbl ? 8 : 16, 1'h0);
		for (int k = 0; k < nb; k++)
			bitout(d[k], dbl ? 8 : 16, spk);
		bitout(fs, st, 1'h0);
		if (two)
			bitout(1'h1, dbl ? 8 : 16, 1'h0);
	endtask
endmodule // urx_tx_model

/* verif/urx_top_sva.sv */
// assertions on the apb side and shared settings
// assumes a bind into urx_top, one clock
`timescale 1ns/1ns
module urx_top_sva (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// settings
	input wire logic [2:0] char_size_sel,
	input wire logic two_stop_sel,
	input wire logic double_speed_sel
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic wr, ok;
	assign wr = pready && psel && pwrite && paddr == 12'h000;
	assign ok = paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008;
	property p_answer; psel && !penable |=> pready; endproperty
	a_answer: assert property (p_answer) else $error("late answer");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("long answer");
	property p_refuse; pready && !ok |-> pslverr && prdata == 32'h0; endproperty
	a_refuse: assert property (p_refuse) else $error("unmapped taken");
	property p_err; pslverr |-> pready && !ok; endproperty
	a_err: assert property (p_err) else $error("stray error");
	property p_size; wr |=> char_size_sel == $past(pwdata[4:2]); endproperty
	a_size: assert property (p_size) else $error("size");
	property p_speed; wr |=> double_speed_sel == $past(pwdata[1]); endproperty
	a_speed: assert property (p_speed) else $error("speed");
	property p_two; wr |=> two_stop_sel == $past(pwdata[5]); endproperty
	a_two: assert property (p_two) else $error("stops");
	property p_still;
		!$stable({char_size_sel, two_stop_sel, double_speed_sel}) |-> $past(wr);
	endproperty
	a_still: assert property (p_still) else $error("setting moved");
	c_wr: cover property (wr);
	c_refuse: cover property (pslverr);
	c_full: cover property (pready && paddr == 12'h004 && prdata[3]);
endmodule // urx_top_sva
bind urx_top urx_top_sva urx_top_sva_inst (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.char_size_sel(char_size_sel), .two_stop_sel(two_stop_sel),
	.double_speed_sel(double_speed_sel));

/* verif/urx_top_tb.sv */
// self-checking bench: apb master, answer queue, serial far side
// assumes urx_tx_model on the line and the bound checker
`timescale 1ns/1ns
module urx_top_tb;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, pready, pslverr, tick, line, two, dbl;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, v;
	logic [2:0] csz, sz[5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
	logic [64:0] q[$], e;
	int seed = 32'h8DB5, n_fail = 0, num_checks = 0;
	always #50 pclk = ~pclk;
	urx_top urx_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.sample_tick(tick), .rx_serial_pin(line), .char_size_sel(csz),
		.two_stop_sel(two), .double_speed_sel(dbl));
	urx_tx_model urx_tx_model_inst (.pclk(pclk), .dbl(dbl), .tick(tick),
		.line(line));
	task automatic miss(input string s);
		n_fail++;
		$display("mismatch %0t %s", $time, s);
	endtask
	task automatic test_done();
		if (q.size() != 0)
			miss("answers missing");
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cmp(input logic [32:0] got, input logic [64:0] x);
		num_checks++;
		if (got !== {x[64], x[31:0] & x[63:32]})
			miss("apb answer");
	endtask
	// answer monitor: oldest note against each pready
	always @(posedge pclk)
		if (pready === 1'h1)
		begin
			e = q.size() > 0 ? q.pop_front() : {1'h1, 64'h0};
			cmp({pslverr, prdata & e[63:32]}, e);
		end
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, input logic [31:0] m, input logic x);
		int i;
		i = 0;
		q.push_back({x, m, d});
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
		begin
			@(posedge pclk);
			i++;
		end
		while (pready !== 1'h1 && i < 40);
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
		if (i >= 40)
		begin
			miss("no pready");
			test_done();
		end
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] d,
		input logic [31:0] m);
		apb(1'h0, a, d, m, 1'h0);
	endtask
	task automatic wctl(input logic f, input logic d, input logic [2:0] s,
		input logic ts);
		apb(1'h1, 12'h000, {25'h0, 1'h1, ts, s, d, f}, 32'h0, 1'h0);
	endtask
	task automatic take(input logic [7:0] d, input logic [31:0] st,
		input logic [31:0] m);
		rd(12'h004, st, m);
		rd(12'h008, {24'h0, d}, 32'hFFFFFFFF);
	endtask
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		rd(12'h000, 32'h0000000C, 32'h000001FF);
		apb(1'h0, 12'h00C, 32'h0, 32'hFFFFFFFF, 1'h1);
		apb(1'h1, 12'h004, 32'h1F, 32'h0, 1'h0);
		rd(12'h004, 32'h0, 32'h1F);
		$display("test reset done");
		for (int m = 0; m < 2; m++)
			foreach (sz[k])
			begin
				v = $random(seed);
				wctl(1'h0, m[0], sz[k], 1'h0);
				urx_tx_model_inst.send(v[9:0], (k == 4) ? 9 : k + 5, 1'h1, 1'h0,
					16 >> m, 1'h1);
				take(v[7:0] & ~(8'hFF << ((k == 4) ? 9 : k + 5)),
					{29'h0, v[8], 2'h1}, (k == 4) ? 32'h1F : 32'h1B);
			end
		$display("test sizes done");
		for (int m = 0; m < 2; m++)
		begin
			v = $random(seed);
			wctl(1'h0, m[0], 3'h3, 1'h0);
			for (int j = 0; j < 3; j++)
				urx_tx_model_inst.send({2'h0, v[8*j +: 8]}, 8, 1'h1, 1'h0,
					m ? 8 : 10, 1'h0);
			// last frame is dropped as overrun one cycle after its stop vote
			repeat (4) @(posedge pclk);
			take(v[7:0], 32'h9, 32'h1B);
			take(v[15:8], 32'h1, 32'h13);
			rd(12'h004, 32'h0, 32'h1);
		end
		$display("test back to back done");
		v = $random(seed);
		wctl(1'h0, 1'h0, 3'h3, 1'h0);
		urx_tx_model_inst.bitout(1'h0, 3, 1'h0);
		urx_tx_model_inst.bitout(1'h1, 32, 1'h0);
		urx_tx_model_inst.send(v[9:0], 8, 1'h1, 1'h0, 16, 1'h0);
		take(v[7:0], 32'h1, 32'h1B);
		rd(12'h004, 32'h0, 32'h1);
		$display("test spike done");
		wctl(1'h1, 1'h0, 3'h7, 1'h0);
		for (int j = 0; j < 3; j++)
			urx_tx_model_inst.send({1'h0, j == 1, v[8*j +: 8]}, 9, 1'h1, 1'h0,
				16, 1'h0);
		take(v[15:8], 32'h5, 32'h1F);
		rd(12'h004, 32'h0, 32'h1);
		wctl(1'h0, 1'h0, 3'h7, 1'h0);
		urx_tx_model_inst.send({2'h0, v[31:24]}, 9, 1'h1, 1'h0, 16, 1'h0);
		take(v[31:24], 32'h1, 32'h1F);
		wctl(1'h1, 1'h0, 3'h3, 1'h1);
		urx_tx_model_inst.send(10'h0C3, 8, 1'h0, 1'h1, 16, 1'h0);
		urx_tx_model_inst.send(10'h03C, 8, 1'h1, 1'h1, 16, 1'h0);
		take(8'h3C, 32'h1, 32'h1B);
		wctl(1'h0, 1'h0, 3'h3, 1'h1);
		urx_tx_model_inst.send(10'h0C3, 8, 1'h0, 1'h1, 16, 1'h0);
		take(8'hC3, 32'h3, 32'h1B);
		$display("test filter done");
		apb(1'h1, 12'h000, 32'h000000CC, 32'h0, 1'h0);
		urx_tx_model_inst.send(10'h103, 9, 1'h1, 1'h0, 16, 1'h0);
		take(8'h03, 32'h11, 32'h1F);
		wctl(1'h0, 1'h0, 3'h3, 1'h0);
		urx_tx_model_inst.send(10'h0A5, 8, 1'h1, 1'h0, 16, 1'h0);
		apb(1'h1, 12'h000, 32'h0000000C, 32'h0, 1'h0);
		wctl(1'h0, 1'h0, 3'h3, 1'h0);
		rd(12'h004, 32'h0, 32'h1F);
		$display("test parity and flush done");
		test_done();
	end
	initial
	begin
		repeat (90000) @(posedge pclk);
		miss("timeout");
		test_done();
	end
endmodule // urx_top_tb
